// [logic/qrb_map.svh]
// Opcodes, register map, field positions and phase counts of the sequencer.
// Functional notes
// - Wrap setting enables wrapping for later quad I/O reads, else reads run linear.
// - Wrapped output starts at the given address and cycles inside its aligned section.
// - Wrap-disable bit clear turns wrapping on; set turns it off.
// - Wrap-length field 00/01/10/11 selects 8/16/32/64 bytes; ignored when disabled.
// - Wrap-disable bit is set at reset; host rewrites it to enter wrap mode.
// - Stored wrap bits govern every later standard-mode quad I/O read and quad I/O word read until rewritten.
// - Quad I/O read in quad command mode never wraps.
// - Quad command mode dummy count follows the read parameter bits, default zero.
// - Mode byte counts as dummy clocks; default data follows the mode byte.
// - Continuous read works for quad I/O read in quad command mode too.
// - Word read: host gives even address; device waits two dummy clocks.
// - Word read is accepted only with the quad enable flag set.
// - Word read advances the address by one after every byte.
// - Word read key 10 makes the next read skip its opcode.
// - Wrap setting also applies to word reads in standard mode.
// - Octal word read: host aligns address to 16; no dummy clocks follow.
// - Octal word read is accepted only with the quad enable flag set.
// - Octal word read: mode bits 5:4 decide continuation; the other six mode bits are ignored.
// - Octal word read key 10 lets the next read start with the address.
// - Quad I/O read key 10 makes the next read skip its opcode.
`ifndef QRB_MAP_SVH
`define QRB_MAP_SVH
`define OP_QIO_READ  8'heb
`define OP_QIO_WORD  8'he7
`define OP_OCT_WORD  8'he3
`define OP_WRAP_CFG  8'h77
`define CRM_KEY      2'h2
`define WRAP_RST     3'h1
`define SPI_OP_LAST  6'h07
`define QCM_OP_LAST  6'h01
`define ADDR_LAST    6'h05
`define MODE_LAST    6'h01
`define WCFG_LAST    6'h1f
`define QIO_DUMMY    3'h4
`define WORD_DUMMY   3'h2
`define OCT_DUMMY    3'h0
`define QCM_DUMMY_LO 3'h0
`define QCM_DUMMY_P2 3'h2
`define QCM_DUMMY_P3 3'h4
`define CTRL_OFS     8'h00
`define STAT_OFS     8'h04
`define CTRL_QEN     0
`define CTRL_QCM     1
`define CTRL_PRM     4
`define STAT_WRAP    0
`define STAT_CONT    3
`define STAT_BUSY    4
`define STAT_OP      8
`endif

// [logic/qrb_pkg.sv]
// Types shared by the quad read sequencer.
package qrb_pkg;
    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_OPC   = 8'h02,
        ST_ADDR  = 8'h04,
        ST_MODE  = 8'h08,
        ST_DUMMY = 8'h10,
        ST_DATA  = 8'h20,
        ST_WCFG  = 8'h40,
        ST_IGN   = 8'h80
    } seq_state_t;
    typedef logic [23:0] flash_addr_t;
endpackage : qrb_pkg

// [logic/quad_read_burst_wrap.sv]
// Quad read sequencer with burst wrap and continuous read, APB configured.
`include "qrb_map.svh"
module quad_read_burst_wrap import qrb_pkg::*; (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link.
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic [3:0]  io_i,
    output logic      [3:0]  io_o,
    output logic      [3:0]  io_oe,
    // Array read port.
    output flash_addr_t      mem_addr,
    input  wire logic [7:0]  mem_rdata
);
    logic        sck_s1, sck_s2, sck_s3, cs_s1, cs_s2;
    logic [3:0]  io_s1, io_s2;
    logic        rise, fall, sel;
    logic        qen_q, qcm_q;
    logic [1:0]  prm_q;
    logic [31:0] prdata_q, rd_d;
    logic        pready_q, pslverr_q, hit;
    seq_state_t  state_q;
    logic [5:0]  cnt_q, op_last;
    logic [31:0] sh_q, sh_d;
    logic [7:0]  op_q, cont_op_q;
    logic        cmd_qcm_q, wrap_act_q, cont_q, nib_q, quad_in, op_ok;
    flash_addr_t addr_q, addr_nx;
    logic [2:0]  wrap_q, dum_q, dseen_q;
    logic [5:0]  wmask;
    logic [3:0]  lo_q, io_o_q, io_oe_q;

    // Link pins pass two flip-flops; the third sclk stage only finds edges.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            cs_s1  <= 1'b1;
            cs_s2  <= 1'b1;
            io_s1  <= 4'h0;
            io_s2  <= 4'h0;
        end else begin
            sck_s1 <= sclk;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            cs_s1  <= cs_n;
            cs_s2  <= cs_s1;
            io_s1  <= io_i;
            io_s2  <= io_s1;
        end
    end

    assign rise = sck_s2 & ~sck_s3;
    assign fall = ~sck_s2 & sck_s3;
    assign sel  = ~cs_s2;

    // APB: zero wait states, unmapped addresses answer with an error.
    assign hit = (paddr == `CTRL_OFS) || (paddr == `STAT_OFS);

    always_comb begin
        rd_d = 32'h0000_0000;
        if (paddr == `CTRL_OFS) begin
            rd_d[`CTRL_QEN]       = qen_q;
            rd_d[`CTRL_QCM]       = qcm_q;
            rd_d[`CTRL_PRM +: 2]  = prm_q;
        end else if (paddr == `STAT_OFS) begin
            rd_d[`STAT_WRAP +: 3] = wrap_q;
            rd_d[`STAT_CONT]      = cont_q;
            rd_d[`STAT_BUSY]      = sel;
            rd_d[`STAT_OP +: 8]   = op_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q <= psel & ~penable;
            if (psel && !penable) begin
                pslverr_q <= ~hit;
                prdata_q  <= pwrite ? 32'h0000_0000 : rd_d;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qen_q <= 1'b0;
            qcm_q <= 1'b0;
            prm_q <= 2'h0;
        end else if (psel && penable && pready_q && pwrite &&
                     paddr == `CTRL_OFS) begin
            qen_q <= pwdata[`CTRL_QEN];
            qcm_q <= pwdata[`CTRL_QCM];
            prm_q <= pwdata[`CTRL_PRM +: 2];
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // Opcode in standard mode and the wrap bytes shift in on one line.
    always_comb begin
        quad_in = (state_q == ST_OPC) ? qcm_q : (state_q != ST_WCFG);
        sh_d    = quad_in ? {sh_q[27:0], io_s2} : {sh_q[30:0], io_s2[0]};
        op_last = qcm_q ? `QCM_OP_LAST : `SPI_OP_LAST;
        case (sh_d[7:0])
            `OP_QIO_READ: op_ok = qen_q;
            `OP_QIO_WORD: op_ok = qen_q & ~qcm_q;
            `OP_OCT_WORD: op_ok = qen_q & ~qcm_q;
            `OP_WRAP_CFG: op_ok = ~qcm_q;
            default:      op_ok = 1'b0;
        endcase
    end

    // Mode byte takes the default dummy clocks in quad command mode.
    function automatic logic [2:0] dummy_of(input logic [7:0] op,
                                            input logic       q,
                                            input logic [1:0] p);
        if (op == `OP_QIO_WORD) return `WORD_DUMMY;
        if (op == `OP_OCT_WORD) return `OCT_DUMMY;
        if (!q) return `QIO_DUMMY;
        case (p)
            2'h2:    return `QCM_DUMMY_P2;
            2'h3:    return `QCM_DUMMY_P3;
            default: return `QCM_DUMMY_LO;
        endcase
    endfunction : dummy_of

    // Wrapped advance keeps the section base and steps the low bits only.
    always_comb begin
        case (wrap_q[2:1])
            2'h0:    wmask = 6'h07;
            2'h1:    wmask = 6'h0f;
            2'h2:    wmask = 6'h1f;
            default: wmask = 6'h3f;
        endcase
        if (wrap_act_q) begin
            addr_nx = {addr_q[23:6],
                       (addr_q[5:0] & ~wmask) |
                       ((addr_q[5:0] + 6'h01) & wmask)};
        end else begin
            addr_nx = addr_q + 24'h00_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= ST_IDLE;
            cnt_q      <= 6'h00;
            sh_q       <= 32'h0000_0000;
            op_q       <= 8'h00;
            cmd_qcm_q  <= 1'b0;
            addr_q     <= 24'h00_0000;
            wrap_act_q <= 1'b0;
            dum_q      <= 3'h0;
            cont_q     <= 1'b0;
            cont_op_q  <= 8'h00;
            wrap_q     <= `WRAP_RST;
        end else if (!sel) begin
            state_q <= ST_IDLE;
            cnt_q   <= 6'h00;
        end else if (state_q == ST_IDLE) begin
            cnt_q     <= 6'h00;
            cmd_qcm_q <= qcm_q;
            if (cont_q) begin
                state_q <= ST_ADDR;
                op_q    <= cont_op_q;
            end else begin
                state_q <= ST_OPC;
            end
        end else if (rise) begin
            sh_q  <= sh_d;
            cnt_q <= cnt_q + 6'h01;
            case (state_q)
                ST_OPC: begin
                    if (cnt_q == op_last) begin
                        cnt_q <= 6'h00;
                        op_q  <= sh_d[7:0];
                        if (!op_ok) begin
                            state_q <= ST_IGN;
                        end else if (sh_d[7:0] == `OP_WRAP_CFG) begin
                            state_q <= ST_WCFG;
                        end else begin
                            state_q <= ST_ADDR;
                        end
                    end
                end
                ST_ADDR: begin
                    if (cnt_q == `ADDR_LAST) begin
                        cnt_q      <= 6'h00;
                        addr_q     <= sh_d[23:0];
                        dum_q      <= dummy_of(op_q, cmd_qcm_q, prm_q);
                        wrap_act_q <= ~wrap_q[0] & ~cmd_qcm_q &
                                      (op_q == `OP_QIO_READ ||
                                       op_q == `OP_QIO_WORD);
                        state_q    <= ST_MODE;
                    end
                end
                ST_MODE: begin
                    if (cnt_q == `MODE_LAST) begin
                        cnt_q     <= 6'h00;
                        cont_q    <= sh_d[5:4] == `CRM_KEY;
                        cont_op_q <= op_q;
                        state_q   <= (dum_q == 3'h0) ? ST_DATA : ST_DUMMY;
                    end
                end
                ST_DUMMY: begin
                    if (cnt_q[2:0] == dum_q - 3'h1) begin
                        state_q <= ST_DATA;
                    end
                end
                ST_WCFG: begin
                    if (cnt_q == `WCFG_LAST) begin
                        wrap_q  <= sh_d[6:4];
                        state_q <= ST_IGN;
                    end
                end
                ST_DATA, ST_IGN: begin
                    cnt_q <= 6'h00;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end else if (fall && state_q == ST_DATA && nib_q) begin
            addr_q <= addr_nx;
        end
    end

    // Data leaves high nibble first on falling sclk; pins drive only in data.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nib_q   <= 1'b0;
            lo_q    <= 4'h0;
            io_o_q  <= 4'h0;
            io_oe_q <= 4'h0;
        end else if (!sel || state_q != ST_DATA) begin
            nib_q   <= 1'b0;
            io_oe_q <= 4'h0;
        end else if (fall) begin
            io_oe_q <= 4'hf;
            nib_q   <= ~nib_q;
            if (!nib_q) begin
                io_o_q <= mem_rdata[7:4];
                lo_q   <= mem_rdata[3:0];
            end else begin
                io_o_q <= lo_q;
            end
        end
    end

    assign io_o     = io_o_q;
    assign io_oe    = io_oe_q;
    assign mem_addr = addr_q;

    // Counts dummy clocks seen, for the checks below.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dseen_q <= 3'h0;
        end else if (state_q == ST_MODE) begin
            dseen_q <= 3'h0;
        end else if (rise && state_q == ST_DUMMY) begin
            dseen_q <= dseen_q + 3'h1;
        end
    end

    property p_wrap_section;
        @(posedge pclk) disable iff (!presetn)
        (fall && state_q == ST_DATA && nib_q && wrap_act_q && sel) |=>
        (addr_q[23:6] == $past(addr_q[23:6])) &&
        ((addr_q[5:0] & ~wmask) == ($past(addr_q[5:0]) & ~wmask));
    endproperty
    a_wrap_section: assert property (p_wrap_section)
        else $error("wrapped address left its section");

    property p_linear_step;
        @(posedge pclk) disable iff (!presetn)
        (fall && state_q == ST_DATA && nib_q && !wrap_act_q && sel) |=>
        addr_q == $past(addr_q) + 24'h00_0001;
    endproperty
    a_linear_step: assert property (p_linear_step)
        else $error("linear read did not step by one");

    property p_wrap_enable;
        @(posedge pclk) disable iff (!presetn)
        ($rose(state_q == ST_DATA) && !cmd_qcm_q &&
         op_q == `OP_QIO_READ) |-> wrap_act_q == !wrap_q[0];
    endproperty
    a_wrap_enable: assert property (p_wrap_enable)
        else $error("wrap state disagrees with wrap-disable bit");

    property p_qcm_no_wrap;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_DATA && cmd_qcm_q) |-> !wrap_act_q;
    endproperty
    a_qcm_no_wrap: assert property (p_qcm_no_wrap)
        else $error("read wraps in quad command mode");

    property p_word_dummy;
        @(posedge pclk) disable iff (!presetn)
        ($rose(state_q == ST_DATA) && op_q == `OP_QIO_WORD) |->
        dseen_q == 3'h2;
    endproperty
    a_word_dummy: assert property (p_word_dummy)
        else $error("word read dummy count is not two");

    property p_oct_dummy;
        @(posedge pclk) disable iff (!presetn)
        ($rose(state_q == ST_DATA) && op_q == `OP_OCT_WORD) |->
        dseen_q == 3'h0;
    endproperty
    a_oct_dummy: assert property (p_oct_dummy)
        else $error("octal word read used dummy clocks");

    property p_qcm_dummy;
        @(posedge pclk) disable iff (!presetn)
        ($rose(state_q == ST_DATA) && cmd_qcm_q &&
         op_q == `OP_QIO_READ) |->
        dseen_q == (prm_q == 2'h3 ? 3'h4 : prm_q == 2'h2 ? 3'h2 : 3'h0);
    endproperty
    a_qcm_dummy: assert property (p_qcm_dummy)
        else $error("quad command mode dummy count wrong");

    property p_cont_skip;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_IDLE && sel && cont_q) |=> state_q == ST_ADDR;
    endproperty
    a_cont_skip: assert property (p_cont_skip)
        else $error("continuous read did not skip the opcode");

    property p_quad_gate;
        @(posedge pclk) disable iff (!presetn)
        (sel && rise && state_q == ST_OPC && cnt_q == op_last &&
         sh_d[7:0] == `OP_QIO_WORD && !qen_q) |=> state_q == ST_IGN;
    endproperty
    a_quad_gate: assert property (p_quad_gate)
        else $error("word read accepted without quad enable");

    property p_wrap_hold;
        @(posedge pclk) disable iff (!presetn)
        $changed(wrap_q) |-> $past(state_q) == ST_WCFG;
    endproperty
    a_wrap_hold: assert property (p_wrap_hold)
        else $error("wrap bits changed outside configuration");

    property p_oe_data;
        @(posedge pclk) disable iff (!presetn)
        (io_oe_q != 4'h0) |-> ($past(state_q) == ST_DATA && $past(sel));
    endproperty
    a_oe_data: assert property (p_oe_data)
        else $error("data pins driven outside data phase");

    property p_cv_wrap;
        @(posedge pclk) disable iff (!presetn)
        fall && state_q == ST_DATA && nib_q && wrap_act_q &&
        (addr_q[5:0] & wmask) == wmask;
    endproperty
    c_wrap: cover property (p_cv_wrap);

    property p_cv_cont;
        @(posedge pclk) disable iff (!presetn)
        state_q == ST_IDLE && sel && cont_q;
    endproperty
    c_cont: cover property (p_cv_cont);

    property p_cv_wcfg;
        @(posedge pclk) disable iff (!presetn)
        $changed(wrap_q);
    endproperty
    c_wcfg: cover property (p_cv_wcfg);
endmodule : quad_read_burst_wrap

// [tb/qrb_host.sv]
// Host controller model that drives the quad serial link.
module qrb_host (
    // Clock.
    input  wire logic       pclk,
    // Link.
    output logic            sclk,
    output logic            cs_n,
    output logic      [3:0] io_i,
    input  wire logic [3:0] io_o,
    input  wire logic [3:0] io_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        io_i = 4'h0;
    end

    // One link clock of eight pclk; io_o is taken late in the high phase.
    task automatic tick(input logic [3:0] v, output logic [3:0] o);
        @(posedge pclk);
        sclk <= 1'b0;
        io_i <= v;
        repeat (4) @(posedge pclk);
        sclk <= 1'b1;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        o = io_o;
    endtask : tick

    task automatic start;
        @(posedge pclk);
        cs_n <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : start

    task automatic stop;
        @(posedge pclk);
        sclk <= 1'b0;
        repeat (4) @(posedge pclk);
        cs_n <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask : stop

    // Sends n units msb first: nibbles when q is set, else bits on io_i[0].
    task automatic send(input logic [31:0] v, input int n, input bit q);
        logic [3:0] o;
        for (int i = n - 1; i >= 0; i--)
            tick(q ? v[4*i +: 4] : {3'b000, v[i]}, o);
    endtask : send

    // Released lines toggle every clock so stale values cannot be read.
    task automatic dummy(input int n);
        logic [3:0] o;
        for (int i = 0; i < n; i++)
            tick(~io_i, o);
    endtask : dummy

    task automatic rd(output logic [7:0] b, output logic [3:0] oe);
        logic [3:0] hi;
        logic [3:0] lo;
        tick(~io_i, hi);
        oe = io_oe;
        tick(~io_i, lo);
        oe = oe & io_oe;
        b = {hi, lo};
    endtask : rd
endmodule : qrb_host

// [tb/tb_top.sv]
// Self-checking bench for the quad read sequencer.
module tb_top import qrb_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sclk;
    logic        cs_n;
    logic [3:0]  io_i;
    logic [3:0]  io_o;
    logic [3:0]  io_oe;
    flash_addr_t mem_addr;
    logic [7:0]  mem_rdata;
    logic [31:0] r;
    logic        e;
    int          err_count       = 0;
    int          samples_checked = 0;

    function automatic logic [7:0] pat(input flash_addr_t a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : pat

    assign mem_rdata = pat(mem_addr);

    initial begin
        forever #20 pclk = ~pclk;
    end

    quad_read_burst_wrap dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n),
        .io_i(io_i), .io_o(io_o), .io_oe(io_oe), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata)
    );

    qrb_host host (
        .pclk(pclk), .sclk(sclk), .cs_n(cs_n), .io_i(io_i), .io_o(io_o),
        .io_oe(io_oe)
    );

    task automatic end_of_test;
        if (err_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input bit w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic er);
        int t;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        q = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (t >= 20) begin
            err_count++;
            end_of_test();
        end
    endtask : bus

    task automatic wrap_cfg(input logic [7:0] w);
        host.start();
        host.send(32'h0000_0077, 8, 1'b0);
        host.send(32'h0000_0000, 24, 1'b0);
        host.send({24'h00_0000, w}, 8, 1'b0);
        host.stop();
    endtask : wrap_cfg

    // One read frame; sz of zero means a linear address run.
    task automatic frame(input logic [7:0] op, input bit q, input bit skip,
                         input flash_addr_t a, input logic [7:0] m,
                         input int dum, input int sz, input int n,
                         input bit ok);
        logic [7:0]  b;
        logic [3:0]  oe;
        flash_addr_t x;
        x = a;
        host.start();
        if (!skip)
            host.send({24'h00_0000, op}, q ? 2 : 8, q);
        host.send({8'h00, a}, 6, 1'b1);
        host.send({24'h00_0000, m}, 2, 1'b1);
        host.dummy(dum);
        for (int k = 0; k < n; k++) begin
            host.rd(b, oe);
            chk({24'h00_0000, b}, ok ? pat(x) : 8'h00);
            chk({28'h000_0000, oe}, ok ? 4'hf : 4'h0);
            if (sz == 0)
                x++;
            else
                x[7:0] = (x[7:0] & ~8'(sz - 1))
                         | ((x[7:0] + 8'h01) & 8'(sz - 1));
        end
        host.stop();
    endtask : frame

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        bus(1'b0, 8'h00, 32'h0000_0000, r, e);
        chk(r, 32'h0000_0000);
        bus(1'b1, 8'h04, 32'hffff_ffff, r, e);
        bus(1'b0, 8'h04, 32'h0000_0000, r, e);
        chk(r & 32'h0000_000f, 32'h0000_0001);
        bus(1'b0, 8'h08, 32'h0000_0000, r, e);
        chk({r[31:1], e}, 32'h0000_0001);
        frame(8'he7, 0, 0, 24'h00_0100, 8'h00, 2, 0, 2, 0);
        frame(8'he3, 0, 0, 24'h00_0100, 8'h00, 0, 0, 2, 0);
        bus(1'b1, 8'h00, 32'h0000_0001, r, e);
        frame(8'heb, 0, 0, 24'h00_03be, 8'h00, 4, 0, 4, 1);
        for (int l = 0; l < 4; l++) begin
            wrap_cfg(8'(l << 5));
            bus(1'b0, 8'h04, 32'h0000_0000, r, e);
            chk(r & 32'h0000_0007, 32'(l << 1));
            frame(8'heb, 0, 0, 24'h00_0300 + 24'(3 * (8 << l) - 2),
                  8'h00, 4, 8 << l, 4, 1);
        end
        frame(8'he7, 0, 0, 24'h00_0abe, 8'h00, 2, 64, 4, 1);
        wrap_cfg(8'h10);
        bus(1'b0, 8'h04, 32'h0000_0000, r, e);
        chk(r & 32'h0000_0007, 32'h0000_0001);
        frame(8'heb, 0, 0, 24'h00_07be, 8'h00, 4, 0, 4, 1);
        for (int i = 0; i < 3; i++) begin
            frame(i == 0 ? 8'heb : i == 1 ? 8'he7 : 8'he3, 0, 0,
                  24'h00_0540, 8'h2f, 4 - 2 * i, 0, 2, 1);
            bus(1'b0, 8'h04, 32'h0000_0000, r, e);
            chk(r & 32'h0000_0008, 32'h0000_0008);
            frame(8'h00, 0, 1, 24'h00_0560, 8'hff, 4 - 2 * i, 0, 2,
                  1);
            bus(1'b0, 8'h04, 32'h0000_0000, r, e);
            chk(r & 32'h0000_0008, 32'h0000_0000);
        end
        wrap_cfg(8'h00);
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, 8'h00, 32'(3 | (p << 4)), r, e);
            frame(8'heb, 1, 0, 24'h00_0606, p == 3 ? 8'h20 : 8'h00,
                  p < 2 ? 0 : 2 * p - 2, 0, 4, 1);
        end
        frame(8'h00, 1, 1, 24'h00_0616, 8'h00, 4, 0, 2, 1);
        end_of_test();
    end
endmodule : tb_top
